// ===== core/abs_pkg.sv
package abs_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int INIT_TIME_NS    = 2000;
   localparam int OSC_CAL_TIME_NS = 20000;
   localparam int LOCK_TIME_NS    = 5000;
   localparam int FG_CAL_TIME_NS  = 40000;
   localparam int CNT_W           = 12;
   localparam logic [CNT_W-1:0] INIT_CYCLES =
      CNT_W'((INIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [CNT_W-1:0] OSC_CAL_CYCLES =
      CNT_W'((OSC_CAL_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [CNT_W-1:0] LOCK_CYCLES =
      CNT_W'((LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FG_CAL_CYCLES =
      CNT_W'((FG_CAL_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MANUAL_TRIM_CYCLES = 12'h001;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
   localparam logic [ADDR_W-1:0] PLL_OFFSET    = 8'h08;
   localparam logic [ADDR_W-1:0] LINK_OFFSET   = 8'h0c;
   localparam logic [ADDR_W-1:0] CAL_OFFSET    = 8'h10;
   localparam logic [ADDR_W-1:0] TRIM_OFFSET   = 8'h14;

   localparam int CTRL_SOFT_RESET    = 0;
   localparam int CTRL_LINK_ENABLE   = 1;
   localparam int CTRL_CAL_ENABLE    = 2;
   localparam int CTRL_OSC_CAL_EN    = 3;
   localparam int CTRL_SYNTH_RESET   = 4;
   localparam int CTRL_PIN_TRIG_EN   = 5;
   localparam int CTRL_SOFT_TRIG     = 6;
   localparam int CTRL_OVERRANGE_EN  = 7;
   localparam int CTRL_SYNC_SEL      = 8;
   localparam int CTRL_CAL_STAT_SEL  = 9;
   localparam int CTRL_SERDES_REF_EN = 10;
   localparam int CAL_FOREGROUND     = 0;
   localparam int LINK_FORMAT_LSB    = 0;
   localparam int LINK_FORMAT_W      = 8;

   localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0016;
   localparam logic [31:0] PLL_RESET_VALUE  = 32'h0000_0000;
   localparam logic [31:0] LINK_RESET_VALUE = 32'h0000_0000;
   localparam logic [31:0] CAL_RESET_VALUE  = 32'h0000_0001;
   localparam logic [31:0] TRIM_RESET_VALUE = 32'h0000_0000;
   // Formats from this code upward use 64B/66B, below it 8B/10B
   localparam logic [7:0]  FORMAT_64B66B_FIRST = 8'h08;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       data;
      logic [3:0]        strb;
   } abs_wr_type;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] status;
      logic [31:0] pll;
      logic [31:0] link;
      logic [31:0] cal;
      logic [31:0] trim;
   } abs_view_type;

   typedef enum logic [4:0] {
      PLL_BYPASS  = 5'b00001,
      PLL_HELD    = 5'b00010,
      PLL_TRIM    = 5'b00100,
      PLL_LOCKING = 5'b01000,
      PLL_LOCKED  = 5'b10000
   } abs_pll_state_type;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_RUN  = 3'b010,
      CAL_DONE = 3'b100
   } abs_cal_state_type;

   typedef enum logic [2:0] {
      LINK_IDLE = 3'b001,
      LINK_CGS  = 3'b010,
      LINK_RUN  = 3'b100
   } abs_link_state_type;

   function automatic logic [31:0] applyStrobe(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
      logic [31:0] result;
      result = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            result[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return result;
   endfunction : applyStrobe

   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      return addr == CTRL_OFFSET || addr == STATUS_OFFSET ||
             addr == PLL_OFFSET  || addr == LINK_OFFSET   ||
             addr == CAL_OFFSET  || addr == TRIM_OFFSET;
   endfunction : isMapped

endpackage : abs_pkg

// ===== core/abs_axi_regs.sv
`timescale 1ns/1ps
module abs_axi_regs
   import abs_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire abs_view_type      regView,
   output abs_wr_type             wrReq
);

   typedef struct packed {
      logic              awHeld;
      logic              wHeld;
      logic [ADDR_W-1:0] awAddr;
      logic [31:0]       wData;
      logic [3:0]        wStrb;
      logic              awReady;
      logic              wReady;
      logic              bValid;
      logic [1:0]        bResp;
      logic              arReady;
      logic              rValid;
      logic [31:0]       rData;
      logic [1:0]        rResp;
      abs_wr_type        wr;
   } abs_axi_state_type;

   abs_axi_state_type q;
   abs_axi_state_type d;

   always_comb begin
      d = q;
      d.wr.valid = 1'b0;
      if (awvalid && q.awReady) begin
         d.awHeld = 1'b1;
         d.awAddr = awaddr;
      end
      if (wvalid && q.wReady) begin
         d.wHeld = 1'b1;
         d.wData = wdata;
         d.wStrb = wstrb;
      end
      if (q.bValid && bready) begin
         d.bValid = 1'b0;
      end
      // Response only after both halves, and never over a pending one
      if (q.awHeld && q.wHeld && !q.bValid) begin
         d.awHeld   = 1'b0;
         d.wHeld    = 1'b0;
         d.bValid   = 1'b1;
         d.bResp    = isMapped(q.awAddr) ? RESP_OKAY : RESP_SLVERR;
         d.wr.valid = isMapped(q.awAddr);
         d.wr.addr  = q.awAddr;
         d.wr.data  = q.wData;
         d.wr.strb  = q.wStrb;
      end
      d.awReady = !d.awHeld;
      d.wReady  = !d.wHeld;
      if (q.rValid && rready) begin
         d.rValid = 1'b0;
      end
      if (arvalid && q.arReady) begin
         d.rValid = 1'b1;
         d.rResp  = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (araddr)
            CTRL_OFFSET:   d.rData = regView.ctrl;
            STATUS_OFFSET: d.rData = regView.status;
            PLL_OFFSET:    d.rData = regView.pll;
            LINK_OFFSET:   d.rData = regView.link;
            CAL_OFFSET:    d.rData = regView.cal;
            TRIM_OFFSET:   d.rData = regView.trim;
            default:       d.rData = 32'h0000_0000;
         endcase
      end
      d.arReady = !d.rValid;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         q         <= '0;
         q.awReady <= 1'b1;
         q.wReady  <= 1'b1;
         q.arReady <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign awready = q.awReady;
   assign wready  = q.wReady;
   assign bvalid  = q.bValid;
   assign bresp   = q.bResp;
   assign arready = q.arReady;
   assign rvalid  = q.rValid;
   assign rdata   = q.rData;
   assign rresp   = q.rResp;
   assign wrReq   = q.wr;

endmodule : abs_axi_regs

// ===== core/abs_bringup_core.sv
// Notes on behaviour
// - After soft reset, init-complete flag rises; host polls it.
// - Device reports trim done and lock; host checks both.
// - Finished calibration raises status pin; foreground-done bit only in foreground mode.
// - 8B/10B formats follow receiver sync; 64B/66B ignores it.
// - Data valid needs link up and calibration finished.
`timescale 1ns/1ps
module abs_bringup_core
   import abs_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              pllEnableStrap,
   input  wire logic              refInputSelectStrap,
   input  wire logic              powerDownPin,
   input  wire logic              calTriggerPin,
   input  wire logic              singleEndedSyncInput,
   input  wire logic              timestampDiffInput,
   output logic                   calStatusPin,
   output logic                   linkRunning,
   output logic                   dataValid,
   output logic                   serdesRefClockOutEnable,
   output logic                   overrangeDetectEnable,
   output logic                   auxClockEnable,
   output logic                   singleEndedRefClockSelected
);

   // ---------------------------------------------------------------
   // Pin indices and state
   // ---------------------------------------------------------------
   localparam int PIN_PLL_EN  = 0;
   localparam int PIN_REF_SEL = 1;
   localparam int PIN_PD      = 2;
   localparam int PIN_TRIG    = 3;
   localparam int PIN_SYNC_SE = 4;
   localparam int PIN_TIMESTAMP_DIFF_INPUT   = 5;
   localparam int PIN_COUNT   = 6;

   typedef struct packed {
      logic [PIN_COUNT-1:0] pinMeta;
      logic [PIN_COUNT-1:0] pinSync;
      logic [PIN_COUNT-1:0] pinPrev;
      logic [31:0]          ctrl;
      logic [31:0]          pll;
      logic [31:0]          link;
      logic [31:0]          cal;
      logic [31:0]          trim;
      logic                 initDone;
      logic [CNT_W-1:0]     initCnt;
      abs_pll_state_type    pllState;
      logic [CNT_W-1:0]     pllCnt;
      logic                 oscCalDone;
      logic                 synthLocked;
      abs_cal_state_type    calState;
      logic [CNT_W-1:0]     calCnt;
      logic                 fgDone;
      logic                 calStatus;
      abs_link_state_type   linkState;
      logic                 linkUp;
      logic                 dataOk;
      logic                 serdesRefEn;
      logic                 overrangeEn;
      logic                 auxEn;
      logic                 seRefSel;
   } abs_core_state_type;

   abs_core_state_type q;
   abs_core_state_type d;
   abs_wr_type         wrReq;
   abs_view_type       regView;

   logic [PIN_COUNT-1:0] pinIn;

   assign pinIn = {timestampDiffInput, singleEndedSyncInput, calTriggerPin,
                   powerDownPin, refInputSelectStrap, pllEnableStrap};

   // ---------------------------------------------------------------
   // Register slave
   // ---------------------------------------------------------------
   abs_axi_regs u_regs (
      .clock   (clock),
      .rst     (rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .regView (regView),
      .wrReq   (wrReq)
   );

   always_comb begin
      regView.ctrl   = q.ctrl;
      regView.status = {24'h00_0000, 1'b0, q.dataOk, q.linkUp,
                        q.calState == CAL_RUN, q.fgDone, q.synthLocked,
                        q.oscCalDone, q.initDone};
      regView.pll    = q.pll;
      regView.link   = q.link;
      regView.cal    = q.cal;
      regView.trim   = q.trim;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic powerDown;
      logic pllOn;
      logic softTrig;
      logic pinTrig;
      logic is8b10b;
      logic syncLevel;
      logic calFinished;
      powerDown   = 1'b0;
      pllOn       = 1'b0;
      softTrig    = 1'b0;
      pinTrig     = 1'b0;
      is8b10b     = 1'b0;
      syncLevel   = 1'b0;
      calFinished = 1'b0;
      d = q;
      // Only the second stage and its delayed copy feed any logic
      d.pinMeta = pinIn;
      d.pinSync = q.pinMeta;
      d.pinPrev = q.pinSync;
      powerDown = q.pinSync[PIN_PD];
      pllOn     = q.pinSync[PIN_PLL_EN];

      if (wrReq.valid) begin
         unique case (wrReq.addr)
            CTRL_OFFSET: d.ctrl = applyStrobe(q.ctrl, wrReq.data, wrReq.strb);
            PLL_OFFSET:  d.pll  = applyStrobe(q.pll,  wrReq.data, wrReq.strb);
            LINK_OFFSET: d.link = applyStrobe(q.link, wrReq.data, wrReq.strb);
            CAL_OFFSET:  d.cal  = applyStrobe(q.cal,  wrReq.data, wrReq.strb);
            TRIM_OFFSET: d.trim = applyStrobe(q.trim, wrReq.data, wrReq.strb);
            default: ;
         endcase
      end
      // Trigger is the written 0-to-1 edge, a rewrite of 1 does nothing
      softTrig = d.ctrl[CTRL_SOFT_TRIG] & ~q.ctrl[CTRL_SOFT_TRIG];
      pinTrig  = q.ctrl[CTRL_PIN_TRIG_EN] & q.pinSync[PIN_TRIG] &
                 ~q.pinPrev[PIN_TRIG];

      // Initialisation after reset or soft reset
      if (!q.initDone) begin
         if (q.initCnt == INIT_CYCLES - 12'h001) begin
            d.initDone = 1'b1;
         end else begin
            d.initCnt = q.initCnt + 12'h001;
         end
      end

      // Sampling synthesiser: held, trim, locking, locked
      unique case (q.pllState)
         PLL_BYPASS: begin
            if (pllOn && q.initDone) begin
               d.pllState = PLL_HELD;
            end
         end
         PLL_HELD: begin
            if (!q.ctrl[CTRL_SYNTH_RESET]) begin
               d.pllState = PLL_TRIM;
               d.pllCnt   = q.ctrl[CTRL_OSC_CAL_EN] ? OSC_CAL_CYCLES
                                                    : MANUAL_TRIM_CYCLES;
            end
         end
         PLL_TRIM: begin
            if (q.pllCnt == 12'h001) begin
               d.oscCalDone = 1'b1;
               d.pllState   = PLL_LOCKING;
               d.pllCnt     = LOCK_CYCLES;
            end else begin
               d.pllCnt = q.pllCnt - 12'h001;
            end
         end
         PLL_LOCKING: begin
            if (q.pllCnt == 12'h001) begin
               d.synthLocked = 1'b1;
               d.pllState    = PLL_LOCKED;
            end else begin
               d.pllCnt = q.pllCnt - 12'h001;
            end
         end
         PLL_LOCKED: ;
      endcase
      // Setting synth reset again drops both flags
      if (q.pllState != PLL_BYPASS && q.ctrl[CTRL_SYNTH_RESET]) begin
         d.pllState    = PLL_HELD;
         d.oscCalDone  = 1'b0;
         d.synthLocked = 1'b0;
      end
      if (!pllOn) begin
         d.pllState    = PLL_BYPASS;
         d.oscCalDone  = 1'b0;
         d.synthLocked = 1'b0;
      end

      // Calibration machine
      if (!q.ctrl[CTRL_CAL_ENABLE] || powerDown || !q.initDone) begin
         d.calState  = CAL_IDLE;
         d.fgDone    = 1'b0;
         d.calStatus = 1'b0;
      end else begin
         unique case (q.calState)
            CAL_IDLE, CAL_DONE: begin
               // Background mode runs once on enable, foreground waits
               if ((q.cal[CAL_FOREGROUND] && (softTrig || pinTrig)) ||
                   (!q.cal[CAL_FOREGROUND] && q.calState == CAL_IDLE)) begin
                  d.calState  = CAL_RUN;
                  d.calCnt    = FG_CAL_CYCLES;
                  d.fgDone    = 1'b0;
                  d.calStatus = 1'b0;
               end
            end
            CAL_RUN: begin
               if (q.calCnt == 12'h001) begin
                  d.calState  = CAL_DONE;
                  d.calStatus = 1'b1;
                  d.fgDone    = q.cal[CAL_FOREGROUND];
               end else begin
                  d.calCnt = q.calCnt - 12'h001;
               end
            end
         endcase
      end

      // Link machine
      is8b10b   = q.link[LINK_FORMAT_LSB +: LINK_FORMAT_W] <
                  FORMAT_64B66B_FIRST;
      syncLevel = q.ctrl[CTRL_SYNC_SEL] ? q.pinSync[PIN_TIMESTAMP_DIFF_INPUT]
                                        : q.pinSync[PIN_SYNC_SE];
      if (!q.ctrl[CTRL_LINK_ENABLE] || powerDown || !q.initDone) begin
         d.linkState = LINK_IDLE;
      end else begin
         unique case (q.linkState)
            LINK_IDLE: begin
               d.linkState = is8b10b ? LINK_CGS : LINK_RUN;
            end
            LINK_CGS: begin
               if (syncLevel) begin
                  d.linkState = LINK_RUN;
               end
            end
            LINK_RUN: begin
               // Sync low again is a resync request from the receiver
               if (is8b10b && !syncLevel) begin
                  d.linkState = LINK_CGS;
               end
            end
         endcase
      end
      d.linkUp    = d.linkState == LINK_RUN;
      calFinished = q.ctrl[CTRL_CAL_STAT_SEL] ? d.fgDone : d.calStatus;
      d.dataOk    = d.linkUp && calFinished;

      d.serdesRefEn = q.ctrl[CTRL_SERDES_REF_EN] && !powerDown;
      d.overrangeEn = q.ctrl[CTRL_OVERRANGE_EN];
      d.auxEn       = !powerDown;
      d.seRefSel    = q.pinSync[PIN_REF_SEL] && pllOn;

      // Soft reset restarts everything, keeps settings, then self-clears
      if (q.ctrl[CTRL_SOFT_RESET]) begin
         d.ctrl[CTRL_SOFT_RESET] = 1'b0;
         d.initDone    = 1'b0;
         d.initCnt     = '0;
         d.pllState    = PLL_BYPASS;
         d.oscCalDone  = 1'b0;
         d.synthLocked = 1'b0;
         d.calState    = CAL_IDLE;
         d.fgDone      = 1'b0;
         d.calStatus   = 1'b0;
         d.linkState   = LINK_IDLE;
         d.linkUp      = 1'b0;
         d.dataOk      = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         q           <= '0;
         q.ctrl      <= CTRL_RESET_VALUE;
         q.pll       <= PLL_RESET_VALUE;
         q.link      <= LINK_RESET_VALUE;
         q.cal       <= CAL_RESET_VALUE;
         q.trim      <= TRIM_RESET_VALUE;
         q.pllState  <= PLL_BYPASS;
         q.calState  <= CAL_IDLE;
         q.linkState <= LINK_IDLE;
      end else begin
         q <= d;
      end
   end

   assign calStatusPin                = q.calStatus;
   assign linkRunning                 = q.linkUp;
   assign dataValid                   = q.dataOk;
   assign serdesRefClockOutEnable     = q.serdesRefEn;
   assign overrangeDetectEnable       = q.overrangeEn;
   assign auxClockEnable              = q.auxEn;
   assign singleEndedRefClockSelected = q.seRefSel;

endmodule : abs_bringup_core

// ===== verif/abs_rx_model.sv
`timescale 1ns/1ps
module abs_rx_model (
   input  wire logic clock,
   input  wire logic rxReady,
   output logic      syncOut
);
   logic [2:0] cnt_q = 3'h0;
   // Sync only after lanes seen a while, so CGS is really waited on
   // Core clock is the reference itself, a 1x multiple
   always_ff @(posedge clock) begin
      if (!rxReady) cnt_q <= 3'h0;
      else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
      syncOut <= rxReady && cnt_q == 3'h7;
   end
endmodule : abs_rx_model

// ===== verif/abs_bringup_core_props.sv
`timescale 1ns/1ps
module abs_bringup_core_props
   import abs_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        pllEnableStrap,
   input wire logic        powerDownPin,
   input wire logic        calStatusPin,
   input wire logic        linkRunning,
   input wire logic        dataValid,
   input wire logic        auxClockEnable,
   input wire logic        singleEndedRefClockSelected
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence wrBoth;
      awvalid && awready && wvalid && wready;
   endsequence
   wr_answer_a: assert property (wrBoth |-> ##[1:2] bvalid)
      else $error("write response late");
   b_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   r_hold_a: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
   ar_block_a: assert property (rvalid |-> !arready)
      else $error("read taken while busy");
   rd_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   err_zero_a: assert property (
      rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
      else $error("error read carries data");
   data_valid_a: assert property (
      dataValid |-> linkRunning && calStatusPin)
      else $error("data valid too early");
   aux_off_a: assert property (
      $rose(powerDownPin) |-> ##[1:5] !auxClockEnable)
      else $error("aux clocks kept in power down");
   se_ref_a: assert property (
      !pllEnableStrap [*6] |=> !singleEndedRefClockSelected)
      else $error("single ended ref without synth");
endmodule : abs_bringup_core_props

// ===== verif/adc_bringup_sequencer_tb_top.sv
`timescale 1ns/1ps
module adc_bringup_sequencer_tb_top
   import abs_pkg::*;
   ;
   logic        clock = 1'b0, rst = 1'b1, awvalid, wvalid, bready, arvalid;
   logic        rready, awready, wready, bvalid, arready, rvalid, rxReady;
   logic        pllEnableStrap, refInputSelectStrap, powerDownPin, sync;
   logic        calStatusPin, linkRunning, dataValid, overrangeDetectEnable;
   logic        auxClockEnable, singleEndedRefClockSelected, serdesEn;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        cal_trigger_pin = 1'b0, timestamp_diff_input = 1'b0;
   int          errorCnt = 0, compares = 0;
   always #5 clock = ~clock;
   abs_rx_model rx (.clock, .rxReady, .syncOut(sync));
   abs_bringup_core dut (.clock, .rst, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .pllEnableStrap,
      .refInputSelectStrap, .powerDownPin, .calTriggerPin(cal_trigger_pin),
      .singleEndedSyncInput(sync), .timestampDiffInput(timestamp_diff_input), .calStatusPin,
      .linkRunning, .dataValid, .serdesRefClockOutEnable(serdesEn),
      .overrangeDetectEnable, .auxClockEnable, .singleEndedRefClockSelected);
   task automatic endOfTest();
      $display("errorCnt %0d compares %0d", errorCnt, compares);
      if (errorCnt == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : endOfTest
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
         errorCnt++;
      end
   endtask : chk
   task automatic guard(input int n);
      if (n >= 3000) begin
         errorCnt++;
         endOfTest();
      end
   endtask : guard
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 3000);
      r = bresp;
      bready <= 1'b0;
      guard(n);
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 3000);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      guard(n);
      @(posedge clock);
   endtask : rd
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         rd(STATUS_OFFSET);
         n++;
      end while (d[b] !== 1'b1 && n < 3000);
      guard(n);
      chk({31'h0, d[b]}, 32'h1);
   endtask : poll
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, rxReady} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
      {pllEnableStrap, refInputSelectStrap, powerDownPin} = 3'b110;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(CTRL_OFFSET); chk(d, CTRL_RESET_VALUE);
      rd(CAL_OFFSET); chk(d, CAL_RESET_VALUE);
      rd(8'h40); chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h40, 32'h1); chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(CTRL_OFFSET, CTRL_RESET_VALUE | 32'h1);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rd(STATUS_OFFSET); chk({31'h0, d[0]}, 32'h0);
      poll(0);
      $display("init test done");
      wr(PLL_OFFSET, 32'h4a);
      wr(CTRL_OFFSET, 32'h0);
      wr(LINK_OFFSET, 32'h0);
      rd(STATUS_OFFSET); chk({31'h0, d[2]}, 32'h0);
      poll(1); poll(2);
      chk({31'h0, singleEndedRefClockSelected}, 32'h1);
      $display("synth test done");
      wr(CAL_OFFSET, 32'h1);
      wr(CTRL_OFFSET, 32'h4);
      wr(CTRL_OFFSET, 32'h44);
      chk({31'h0, calStatusPin}, 32'h0);
      poll(3); chk({31'h0, calStatusPin}, 32'h1);
      wr(CTRL_OFFSET, 32'h24);
      cal_trigger_pin <= 1'b1;
      rd(STATUS_OFFSET); rd(STATUS_OFFSET);
      chk({31'h0, calStatusPin}, 32'h0);
      poll(3); chk({31'h0, calStatusPin}, 32'h1);
      $display("cal test done");
      wr(CTRL_OFFSET, 32'h86);
      rd(STATUS_OFFSET); chk({31'h0, d[5]}, 32'h0);
      chk({31'h0, overrangeDetectEnable}, 32'h1);
      rxReady <= 1'b1;
      poll(5); poll(6); chk({31'h0, dataValid}, 32'h1);
      wr(CTRL_OFFSET, 32'h186);
      rd(STATUS_OFFSET); chk({31'h0, d[5]}, 32'h0);
      timestamp_diff_input <= 1'b1;
      poll(5);
      rxReady <= 1'b0;
      wr(CTRL_OFFSET, 32'h84);
      wr(LINK_OFFSET, {24'h0, FORMAT_64B66B_FIRST});
      wr(CTRL_OFFSET, 32'h486);
      poll(5); chk({31'h0, linkRunning}, 32'h1);
      chk({31'h0, serdesEn}, 32'h1);
      $display("link test done");
      powerDownPin <= 1'b1;
      rd(STATUS_OFFSET); rd(STATUS_OFFSET);
      chk({31'h0, auxClockEnable}, 32'h0);
      chk({31'h0, serdesEn}, 32'h0);
      powerDownPin <= 1'b0;
      pllEnableStrap <= 1'b0;
      rd(STATUS_OFFSET); rd(STATUS_OFFSET); rd(STATUS_OFFSET);
      chk({31'h0, singleEndedRefClockSelected}, 32'h0);
      $display("pin test done");
      endOfTest();
   end
endmodule : adc_bringup_sequencer_tb_top
bind abs_bringup_core abs_bringup_core_props u_props (.clock, .rst,
   .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
   .arready, .rvalid, .rready, .rdata, .rresp, .pllEnableStrap,
   .powerDownPin, .calStatusPin, .linkRunning, .dataValid,
   .auxClockEnable, .singleEndedRefClockSelected);
